// ---- design/lsir_defines.vh ----
// Register indices, field positions, reset values and timing for the line status bank
`ifndef LSIR_DEFINES_VH
`define LSIR_DEFINES_VH

// Register indices; byte address is four times the index
`define LSIR_IDX_W          10
`define LSIR_IDX_TXJMODE    10'h021
`define LSIR_IDX_RXJMODE    10'h027
`define LSIR_IDX_CNTCTRL    10'h031
`define LSIR_IDX_TERM       10'h032
`define LSIR_IDX_LINEEN     10'h033
`define LSIR_IDX_FAULTEN    10'h034
`define LSIR_IDX_EDGE       10'h035
`define LSIR_IDX_LIVE       10'h036
`define LSIR_IDX_GAIN       10'h037
`define LSIR_IDX_TXGAP      10'h038
`define LSIR_IDX_RXGAP      10'h039
`define LSIR_IDX_LINEFLAG   10'h03a
`define LSIR_IDX_FAULTFLAG  10'h03b
`define LSIR_IDX_CNTHI      10'h03c
`define LSIR_IDX_CNTLO      10'h03d

// Count control fields
`define LSIR_CC_TRIG        0
`define LSIR_CC_MODE        1
`define LSIR_CC_SEL_LO      2
`define LSIR_CC_SEL_HI      3
`define LSIR_CC_FCC         4
`define LSIR_CC_MASK        8'h1f
`define LSIR_SEL_COUNT      2'h1
`define LSIR_GAP_MODE_BIT   5

// Termination field positions and reset value
`define LSIR_RTERM_LO       0
`define LSIR_RTERM_HI       2
`define LSIR_TTERM_LO       3
`define LSIR_TTERM_HI       5
`define LSIR_TERM_RESET     8'h07
`define LSIR_TERM_MASK      8'h3f

// Line flag / enable / edge / live bits
`define LSIR_B_DF           2
`define LSIR_B_LOS          0
`define LSIR_LINE_MASK      8'h05
// Fault flag / enable bits
`define LSIR_B_TMPL         6
`define LSIR_B_TXJA         5
`define LSIR_B_RXJA         4
`define LSIR_B_ZRUN         2
`define LSIR_B_VIOL         1
`define LSIR_B_CNTOV        0
`define LSIR_FAULT_MASK     8'h77

// Zero-run limits (zeros beyond which an error is declared)
`define LSIR_ZRUN_AMI       7'd15
`define LSIR_ZRUN_AMI_FCC   7'd80
`define LSIR_ZRUN_B8ZS      7'd7

// Timing
`define LSIR_CLK_HZ         25000000
`define LSIR_REPORT_S       1
`define LSIR_HTRANS_NONSEQ  2'h2

`endif

// ---- design/lsir_regs.v ----
// Line status, termination, zero-run counter and line interrupt register bank on AHB-Lite
//
// Notes on behaviour
// - Zero-run events are counted in a 16-bit counter only when count select is 01.
// - Report mode 0: trigger 0-to-1 edge copies counter into high and low report bytes.
// - Report mode 1: counter copied into report bytes once per second automatically.
// - Transmit termination codes 000-011 pick 75/120/100/110 ohm; 1xx reserved.
// - Receive termination uses the same codes; 1xx bypasses internal matching.
// - Interrupt output asserts only for set flags whose enable bit is 1.
// - Edge select 0 flags rising change only; 1 flags either change of live bit.
// - Live driver-fail at bit 2 and signal-loss at bit 0, read-only, 1 when detected.
// - Read-only five-bit gain band, 2 dB steps; codes 10101 and above are top band.
// - Jitter readout shows current pointer gap, or peak-to-peak since last read.
// - Writing a 1 to a jitter readout clears its seven interval bits.
// - Status flags stay set until software writes 1 at their position.
// - Template-overflow flag set when summed multi-UI template exceeds +63.
// - Separate tx and rx jitter FIFO flags set on overflow or underflow.
// - Separate flags for zero-run error and bipolar violation on received stream.
// - Counter-overflow flag set when the 16-bit zero-run counter wraps.
// - Zero-run error: over 15 zeros in AMI, over 7 in B8ZS, by default.
// - Report bytes hold last transferred 16-bit counter value, read-only.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lsir_defines.vh"

// Pointer gap meter: current or peak-to-peak interval
module lsir_gap_meter #(
   parameter GAP_W = 7
) (
   input  wire             clk_sys,
   input  wire             rst_b,
   input  wire [GAP_W-1:0] gapIn,
   input  wire             peakMode,
   input  wire             readHit,
   input  wire             clearHit,
   output reg  [GAP_W-1:0] gapOut_r
);
   reg  [GAP_W-1:0] gapMin_r;
   reg  [GAP_W-1:0] gapMax_r;
   wire [GAP_W-1:0] minNxt;
   wire [GAP_W-1:0] maxNxt;

   // Window restarts from the live gap after a read or clear
   assign minNxt = (readHit || clearHit || gapIn < gapMin_r) ? gapIn : gapMin_r;
   assign maxNxt = (readHit || clearHit || gapIn > gapMax_r) ? gapIn : gapMax_r;

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         gapMin_r <= {GAP_W{1'b0}};
         gapMax_r <= {GAP_W{1'b0}};
         gapOut_r <= {GAP_W{1'b0}};
      end else begin
         gapMin_r <= minNxt;
         gapMax_r <= maxNxt;
         if (clearHit)
            gapOut_r <= {GAP_W{1'b0}};
         else if (peakMode)
            gapOut_r <= maxNxt - minNxt;
         else
            gapOut_r <= gapIn;
      end
   end
endmodule // lsir_gap_meter

module lsir_regs #(
   parameter integer SECOND_CYCLES = `LSIR_REPORT_S * `LSIR_CLK_HZ,
   parameter         CNT_W         = 16,
   parameter         GAP_W         = 7
) (
   input  wire             clk_sys,
   input  wire             rst_b,
   // AHB-Lite slave
   input  wire             hsel,
   input  wire [11:0]      haddr,
   input  wire [1:0]       htrans,
   input  wire             hwrite,
   input  wire [2:0]       hsize,
   input  wire [31:0]      hwdata,
   input  wire             hready,
   output reg              hreadyout,
   output reg              hresp,
   output reg  [31:0]      hrdata,
   // Analog line status pins
   input  wire             driverFailPin,
   input  wire             signalLossPin,
   input  wire [4:0]       gainBandPin,
   // Line-side logic on clk_sys
   input  wire             rxBitValid,
   input  wire             rxBitMark,
   input  wire             lineCodeAmi,
   input  wire             violationEvent,
   input  wire             templateOvfEvent,
   input  wire             txFifoFaultEvent,
   input  wire             rxFifoFaultEvent,
   input  wire [GAP_W-1:0] txPointerGapIn,
   input  wire [GAP_W-1:0] rxPointerGapIn,
   // Outputs
   output reg  [1:0]       txImpedance_r,
   output reg  [1:0]       rxImpedance_r,
   output reg              rxExternalTerm_r,
   output reg              irqOut_r
);
   // Software-visible registers
   reg  [7:0]       cntCtrl_r;
   reg  [7:0]       term_r;
   reg  [7:0]       lineEn_r;
   reg  [7:0]       faultEn_r;
   reg  [7:0]       edgeSel_r;
   reg  [7:0]       lineFlag_r;
   reg  [7:0]       faultFlag_r;
   reg              txGapPeakMode_r;
   reg              rxGapPeakMode_r;
   reg  [CNT_W-1:0] report_r;
   // Internal state
   reg  [CNT_W-1:0] zeroCount_r;
   reg  [31:0]      secCount_r;
   reg              trigPrev_r;
   reg  [6:0]       zeroRun_r;
   reg  [2:0]       dfSync_r;
   reg  [2:0]       losSync_r;
   reg  [4:0]       gainMeta_r;
   reg  [4:0]       gainBand_r;
   // Data phase capture
   reg              wrPend_r;
   reg  [`LSIR_IDX_W-1:0] wrIdx_r;

   wire [GAP_W-1:0] txPointerGap;
   wire [GAP_W-1:0] rxPointerGap;

   // Bus decode
   wire             accept  = hsel && hready && (htrans == `LSIR_HTRANS_NONSEQ);
   wire [`LSIR_IDX_W-1:0] aIdx = haddr[11:2];
   wire             rdHit   = accept && !hwrite;
   wire             wrHit   = wrPend_r;
   wire [7:0]       wData   = hwdata[7:0];

   wire             txGapRead  = rdHit && (aIdx == `LSIR_IDX_TXGAP);
   wire             rxGapRead  = rdHit && (aIdx == `LSIR_IDX_RXGAP);
   wire             txGapClear = wrHit && (wrIdx_r == `LSIR_IDX_TXGAP) && (|wData[GAP_W-1:0]);
   wire             rxGapClear = wrHit && (wrIdx_r == `LSIR_IDX_RXGAP) && (|wData[GAP_W-1:0]);

   // Live status after synchronisers
   wire             dfLive  = dfSync_r[1];
   wire             losLive = losSync_r[1];
   wire             dfRise  = dfSync_r[1] && !dfSync_r[2];
   wire             dfFall  = !dfSync_r[1] && dfSync_r[2];
   wire             losRise = losSync_r[1] && !losSync_r[2];
   wire             losFall = !losSync_r[1] && losSync_r[2];

   // Edge select picks rising-only or any change
   wire dfEvent  = dfRise || (edgeSel_r[`LSIR_B_DF] && dfFall);
   wire losEvent = losRise || (edgeSel_r[`LSIR_B_LOS] && losFall);

   // Zero-run limit depends on line code and criterion bit
   wire [6:0] zeroLimit = !lineCodeAmi ? `LSIR_ZRUN_B8ZS :
                          cntCtrl_r[`LSIR_CC_FCC] ? `LSIR_ZRUN_AMI_FCC :
                          `LSIR_ZRUN_AMI;
   // One error per run, on the first zero past the limit
   wire zeroRunEvent = rxBitValid && !rxBitMark && (zeroRun_r == zeroLimit);

   // Counting and reporting controls
   wire countEnable = (cntCtrl_r[`LSIR_CC_SEL_HI:`LSIR_CC_SEL_LO] == `LSIR_SEL_COUNT);
   wire countInc    = countEnable && zeroRunEvent;
   wire autoMode    = cntCtrl_r[`LSIR_CC_MODE];
   wire secTick     = (secCount_r == SECOND_CYCLES - 1);
   wire manualXfer  = !autoMode && cntCtrl_r[`LSIR_CC_TRIG] && !trigPrev_r;
   wire autoXfer    = autoMode && secTick;
   wire transfer    = manualXfer || autoXfer;
   wire cntWrap     = countInc && (&zeroCount_r);

   // Flag set and clear terms
   wire [7:0] lineSet  = ({7'h0, losEvent} << `LSIR_B_LOS) |
                         ({7'h0, dfEvent} << `LSIR_B_DF);
   wire [7:0] faultSet = ({7'h0, templateOvfEvent} << `LSIR_B_TMPL) |
                         ({7'h0, txFifoFaultEvent} << `LSIR_B_TXJA) |
                         ({7'h0, rxFifoFaultEvent} << `LSIR_B_RXJA) |
                         ({7'h0, zeroRunEvent} << `LSIR_B_ZRUN) |
                         ({7'h0, violationEvent} << `LSIR_B_VIOL) |
                         ({7'h0, cntWrap} << `LSIR_B_CNTOV);
   wire [7:0] lineClr  = (wrHit && wrIdx_r == `LSIR_IDX_LINEFLAG) ? wData : 8'h00;
   wire [7:0] faultClr = (wrHit && wrIdx_r == `LSIR_IDX_FAULTFLAG) ? wData : 8'h00;

   // Read mux, evaluated in the address phase
   reg [7:0] rdByte;
   always @* begin
      rdByte = 8'h00;
      case (aIdx)
         `LSIR_IDX_TXJMODE:   rdByte = {2'h0, txGapPeakMode_r, 5'h00};
         `LSIR_IDX_RXJMODE:   rdByte = {2'h0, rxGapPeakMode_r, 5'h00};
         `LSIR_IDX_CNTCTRL:   rdByte = cntCtrl_r;
         `LSIR_IDX_TERM:      rdByte = term_r;
         `LSIR_IDX_LINEEN:    rdByte = lineEn_r;
         `LSIR_IDX_FAULTEN:   rdByte = faultEn_r;
         `LSIR_IDX_EDGE:      rdByte = edgeSel_r;
         `LSIR_IDX_LIVE:      rdByte = {5'h00, dfLive, 1'b0, losLive};
         `LSIR_IDX_GAIN:      rdByte = {3'h0, gainBand_r};
         `LSIR_IDX_TXGAP:     rdByte = {1'b0, txPointerGap};
         `LSIR_IDX_RXGAP:     rdByte = {1'b0, rxPointerGap};
         `LSIR_IDX_LINEFLAG:  rdByte = lineFlag_r;
         `LSIR_IDX_FAULTFLAG: rdByte = faultFlag_r;
         `LSIR_IDX_CNTHI:     rdByte = report_r[CNT_W-1:CNT_W-8];
         `LSIR_IDX_CNTLO:     rdByte = report_r[7:0];
         default:             rdByte = 8'h00;
      endcase
   end

   // Bus slave: zero wait states, always OKAY
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         wrPend_r  <= 1'b0;
         wrIdx_r   <= {`LSIR_IDX_W{1'b0}};
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend_r  <= accept && hwrite;
         if (accept)
            wrIdx_r <= aIdx;
         // Data stands for the data phase; unmapped reads give zero
         if (rdHit)
            hrdata <= {24'h00_0000, rdByte};
      end
   end

   // Control registers written in the data phase
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cntCtrl_r       <= 8'h00;
         term_r          <= `LSIR_TERM_RESET;
         lineEn_r        <= 8'h00;
         faultEn_r       <= 8'h00;
         edgeSel_r       <= 8'h00;
         txGapPeakMode_r <= 1'b0;
         rxGapPeakMode_r <= 1'b0;
      end else if (wrHit) begin
         case (wrIdx_r)
            `LSIR_IDX_CNTCTRL: cntCtrl_r <= wData & `LSIR_CC_MASK;
            `LSIR_IDX_TERM:    term_r    <= wData & `LSIR_TERM_MASK;
            `LSIR_IDX_LINEEN:  lineEn_r  <= wData & `LSIR_LINE_MASK;
            `LSIR_IDX_FAULTEN: faultEn_r <= wData & `LSIR_FAULT_MASK;
            `LSIR_IDX_EDGE:    edgeSel_r <= wData & `LSIR_LINE_MASK;
            `LSIR_IDX_TXJMODE: txGapPeakMode_r <= wData[`LSIR_GAP_MODE_BIT];
            `LSIR_IDX_RXJMODE: rxGapPeakMode_r <= wData[`LSIR_GAP_MODE_BIT];
            default: ;
         endcase
      end
   end

   // Pin synchronisers; stage 2 holds the previous value for edges
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         dfSync_r   <= 3'h0;
         losSync_r  <= 3'h0;
         gainMeta_r <= 5'h00;
         gainBand_r <= 5'h00;
      end else begin
         dfSync_r   <= {dfSync_r[1:0], driverFailPin};
         losSync_r  <= {losSync_r[1:0], signalLossPin};
         gainMeta_r <= gainBandPin;
         gainBand_r <= gainMeta_r;   // Slow-moving code, top codes pass as top band
      end
   end

   // Zero-run length tracker, saturates past the largest limit
   always @(posedge clk_sys) begin
      if (!rst_b)
         zeroRun_r <= 7'h00;
      else if (rxBitValid) begin
         if (rxBitMark)
            zeroRun_r <= 7'h00;
         else if (zeroRun_r != 7'h7f)
            zeroRun_r <= zeroRun_r + 7'h01;
      end
   end

   // Event counter, one-second timer and report transfer
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         zeroCount_r <= {CNT_W{1'b0}};
         report_r    <= {CNT_W{1'b0}};
         secCount_r  <= 32'h0000_0000;
         trigPrev_r  <= 1'b0;
      end else begin
         trigPrev_r <= cntCtrl_r[`LSIR_CC_TRIG];
         // Timer free-runs in manual mode too, so auto mode starts in phase
         secCount_r <= secTick ? 32'h0000_0000 : secCount_r + 32'h0000_0001;
         if (transfer) begin
            report_r    <= zeroCount_r;
            // An event in the transfer cycle starts the new interval
            zeroCount_r <= countInc ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
         end else if (countInc)
            zeroCount_r <= zeroCount_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Sticky flags: a new event beats a same-cycle clear
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         lineFlag_r  <= 8'h00;
         faultFlag_r <= 8'h00;
      end else begin
         lineFlag_r  <= ((lineFlag_r & ~lineClr) | lineSet) & `LSIR_LINE_MASK;
         faultFlag_r <= ((faultFlag_r & ~faultClr) | faultSet) & `LSIR_FAULT_MASK;
      end
   end

   // Interrupt output and termination selection
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         irqOut_r         <= 1'b0;
         txImpedance_r    <= 2'h0;
         rxImpedance_r    <= 2'h0;
         rxExternalTerm_r <= 1'b0;
      end else begin
         irqOut_r <= |(lineFlag_r & lineEn_r) | |(faultFlag_r & faultEn_r);
         // Reserved transmit codes keep the last valid match
         if (!term_r[`LSIR_TTERM_HI])
            txImpedance_r <= term_r[`LSIR_TTERM_HI-1:`LSIR_TTERM_LO];
         rxImpedance_r    <= term_r[`LSIR_RTERM_HI-1:`LSIR_RTERM_LO];
         rxExternalTerm_r <= term_r[`LSIR_RTERM_HI];
      end
   end

   // Transmit and receive pointer gap readouts
   lsir_gap_meter #(.GAP_W(GAP_W)) txGapMeter (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .gapIn    (txPointerGapIn),
      .peakMode (txGapPeakMode_r),
      .readHit  (txGapRead),
      .clearHit (txGapClear),
      .gapOut_r (txPointerGap)
   );

   lsir_gap_meter #(.GAP_W(GAP_W)) rxGapMeter (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .gapIn    (rxPointerGapIn),
      .peakMode (rxGapPeakMode_r),
      .readHit  (rxGapRead),
      .clearHit (rxGapClear),
      .gapOut_r (rxPointerGap)
   );

   // hsize unused: every access is treated as a whole word
   wire unusedSize = |hsize;

endmodule // lsir_regs
`default_nettype wire

// ---- verification/lsir_regs_assertions.sv ----
// Concurrent checks on the port behaviour of the line status register bank
`timescale 1ns/1ps
`default_nettype none
`include "lsir_defines.vh"
module lsir_regs_assertions #(
   parameter integer SECOND_CYCLES = 20,
   parameter         CNT_W         = 16,
   parameter         GAP_W         = 7
) (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [1:0]  txImpedance_r,
   input wire logic [1:0]  rxImpedance_r,
   input wire logic        rxExternalTerm_r,
   input wire logic        irqOut_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic       take;
   logic       rdTake;
   logic       mapped;
   logic [9:0] idx;
   logic       wrDp_r;
   logic       termDp_r;
   // Address phase decode, as the slave sees it
   assign take   = hsel && hready && htrans == `LSIR_HTRANS_NONSEQ;
   assign rdTake = take && !hwrite;
   assign idx    = haddr[11:2];
   assign mapped = idx inside {`LSIR_IDX_TXJMODE, `LSIR_IDX_RXJMODE,
                               [`LSIR_IDX_CNTCTRL:`LSIR_IDX_CNTLO]};
   // Data phase markers; cleared in reset so no stale write is seen after release
   always @(posedge clk_sys) begin
      wrDp_r   <= rst_b && take && hwrite;
      termDp_r <= rst_b && take && hwrite && idx == `LSIR_IDX_TERM;
   end
   chk_ready_okay: assert property (hreadyout && !hresp)
      else $error("slave stalled or answered with an error");
   chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("read data above the byte lane is not zero");
   chk_unmapped_zero: assert property (rdTake && !mapped |=> hrdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   chk_live_bits: assert property (
      rdTake && idx == `LSIR_IDX_LIVE |=> (hrdata[7:0] & ~`LSIR_LINE_MASK) == 8'h0)
      else $error("live status shows bits outside its two flags");
   chk_gain_width: assert property (
      rdTake && idx == `LSIR_IDX_GAIN |=> hrdata[7:5] == 3'h0)
      else $error("gain readout wider than five bits");
   chk_gap_width: assert property (
      rdTake && (idx == `LSIR_IDX_TXGAP || idx == `LSIR_IDX_RXGAP) |=> !hrdata[7])
      else $error("pointer gap readout wider than seven bits");
   chk_flag_bits: assert property (
      rdTake && idx == `LSIR_IDX_FAULTFLAG |=> (hrdata[7:0] & ~`LSIR_FAULT_MASK) == 8'h0)
      else $error("fault flags show a reserved bit");
   chk_rx_term: assert property (
      termDp_r |-> ##2 rxExternalTerm_r == $past(hwdata[2], 2)
         && (rxExternalTerm_r || rxImpedance_r == $past(hwdata[1:0], 2)))
      else $error("receive termination does not follow the written code");
   chk_tx_term: assert property (
      termDp_r |-> ##2 txImpedance_r ==
         ($past(hwdata[5], 2) ? $past(txImpedance_r) : $past(hwdata[4:3], 2)))
      else $error("transmit termination does not follow the written code");
   chk_irq_hold: assert property ($fell(irqOut_r) |-> $past(wrDp_r, 2))
      else $error("interrupt dropped without a register write");
   // Main scenarios reached
   cov_irq_rise: cover property ($rose(irqOut_r));
   cov_term_write: cover property (termDp_r);
   cov_unmapped: cover property (rdTake && !mapped);
endmodule // lsir_regs_assertions
bind lsir_regs lsir_regs_assertions #(.SECOND_CYCLES(SECOND_CYCLES), .CNT_W(CNT_W),
   .GAP_W(GAP_W)) chk (.*);
`default_nettype wire

// ---- verification/lsir_regs_tb.sv ----
// Self-checking bench for the line status register bank
`timescale 1ns/1ps
`default_nettype none
`include "lsir_defines.vh"
module lsir_regs_tb;
   logic        clk_sys, rst_b, hsel, hwrite, dfPin, losPin, bitValid, bitMark, ami;
   logic        violEv, tmplEv, txEv, rxEv;
   logic [11:0] haddr;
   logic [1:0]  htrans, lastTx;
   logic [31:0] hwdata, rnd;
   logic [4:0]  gain;
   logic [6:0]  txGap, rxGap;
   logic [7:0]  v, fm;
   wire         hreadyout, hresp, rxExt, irq;
   wire  [1:0]  txImp, rxImp;
   wire  [31:0] hrdata;
   integer      mismatches = 0, n_compared = 0, i;
   // Integer model of the zero-run counter and its report bytes
   int          expCount = 0, expReport = 0;
   logic [7:0]  ctrl = 8'h00;
   logic [9:0]  rwIdx [7] = '{10'h021, 10'h027, 10'h031, 10'h032, 10'h033, 10'h034, 10'h035};
   logic [7:0]  rwMask [7] = '{8'h20, 8'h20, 8'h1f, 8'h3f, 8'h05, 8'h77, 8'h05};

   lsir_regs #(.SECOND_CYCLES(20)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .driverFailPin(dfPin),
      .signalLossPin(losPin), .gainBandPin(gain), .rxBitValid(bitValid),
      .rxBitMark(bitMark), .lineCodeAmi(ami), .violationEvent(violEv),
      .templateOvfEvent(tmplEv), .txFifoFaultEvent(txEv), .rxFifoFaultEvent(rxEv),
      .txPointerGapIn(txGap), .rxPointerGapIn(rxGap), .txImpedance_r(txImp),
      .rxImpedance_r(rxImp), .rxExternalTerm_r(rxExt), .irqOut_r(irq));

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // One single AHB transfer; waits on hready in both phases
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= `LSIR_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [7:0] rd;
      xfer(1'b1, idx, d, rd);
   endtask

   task automatic rdChk(input string what, input logic [9:0] idx, input logic [7:0] exp);
      logic [7:0] rd;
      xfer(1'b0, idx, 8'h0, rd);
      check(what, rd, exp);
   endtask

   // One-cycle event pulse: template, tx fifo, rx fifo, violation
   task automatic pulse(input int k);
      {tmplEv, txEv, rxEv, violEv} <= 4'b1000 >> k;
      @(posedge clk_sys);
      {tmplEv, txEv, rxEv, violEv} <= 4'h0;
   endtask

   // A run of received zeros closed by a mark; model counts runs past the limit
   task automatic zeros(input int n);
      bitValid <= 1'b1;
      bitMark  <= 1'b0;
      tick(n);
      if (ctrl[3:2] == `LSIR_SEL_COUNT && n > (!ami ? `LSIR_ZRUN_B8ZS :
          ctrl[4] ? `LSIR_ZRUN_AMI_FCC : `LSIR_ZRUN_AMI))
         expCount++;
      bitMark <= 1'b1;
      tick(1);
      bitValid <= 1'b0;
      tick(1);
   endtask

   // Count control write; a manual trigger edge copies and restarts the model count
   task automatic ctl(input logic [7:0] c);
      if (c[0] && !ctrl[0] && !c[1]) begin
         expReport = expCount;
         expCount  = 0;
      end
      ctrl = c;
      wr(`LSIR_IDX_CNTCTRL, c);
   endtask

   // Hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      tick(20000);
      mismatches++;
      print_verdict();
   end

   initial begin
      rnd = $urandom(32'h315f);
      {rst_b, hsel, hwrite, dfPin, losPin, bitValid, bitMark, ami} = 8'h0;
      {violEv, tmplEv, txEv, rxEv, htrans, haddr, hwdata} = '0;
      {gain, txGap, rxGap} = '0;
      tick(4);
      rst_b <= 1'b1;
      tick(1);
      for (i = 'h31; i <= 'h3d; i++)
         rdChk("reset value", 10'(i), i == 'h32 ? 8'h07 : 8'h00);
      // Read-write registers keep only their defined bits
      repeat (3) for (i = 0; i < 7; i++) begin
         v = 8'($urandom);
         wr(rwIdx[i], v);
         rdChk("rw register", rwIdx[i], v & rwMask[i]);
      end
      wr(10'h030, 8'hff);
      rdChk("unmapped", 10'h030, 8'h00);
      wr(`LSIR_IDX_CNTHI, 8'hff);
      rdChk("read-only count", `LSIR_IDX_CNTHI, 8'h00);
      // Every termination code on both paths
      lastTx = 2'h0;
      for (i = 0; i < 8; i++) begin
         wr(`LSIR_IDX_TERM, {2'b00, 3'(i), 3'(7 - i)});
         tick(2);
         if (i < 4) lastTx = 2'(i);
         check("tx impedance", txImp, lastTx);
         check("rx bypass", rxExt, 7 - i >= 4);
         if (i >= 4) check("rx impedance", rxImp, 7 - i);
      end
      // Fault flags: masked, enabled, held, cleared
      wr(`LSIR_IDX_LINEEN, 8'h00);
      wr(`LSIR_IDX_FAULTEN, 8'h00);
      wr(`LSIR_IDX_FAULTFLAG, 8'hff);
      for (i = 0; i < 4; i++) begin
         fm = (i == 3) ? 8'h02 : 8'h40 >> i;
         pulse(i);
         tick(2);
         check("irq masked", irq, 1'b0);
         rdChk("fault flag set", `LSIR_IDX_FAULTFLAG, fm);
         wr(`LSIR_IDX_FAULTEN, fm);
         tick(2);
         check("irq enabled", irq, 1'b1);
         wr(`LSIR_IDX_FAULTFLAG, ~fm);
         rdChk("flag held", `LSIR_IDX_FAULTFLAG, fm);
         wr(`LSIR_IDX_FAULTFLAG, fm);
         tick(2);
         check("irq cleared", irq, 1'b0);
         wr(`LSIR_IDX_FAULTEN, 8'h00);
      end
      // Live pins and edge selection
      wr(`LSIR_IDX_EDGE, 8'h00);
      wr(`LSIR_IDX_LINEEN, 8'h04);
      dfPin <= 1'b1;
      tick(5);
      rdChk("live status", `LSIR_IDX_LIVE, 8'h04);
      check("driver fail irq", irq, 1'b1);
      wr(`LSIR_IDX_LINEFLAG, 8'h04);
      dfPin <= 1'b0;
      tick(5);
      rdChk("fall ignored", `LSIR_IDX_LINEFLAG, 8'h00);
      wr(`LSIR_IDX_EDGE, 8'h05);
      losPin <= 1'b1;
      tick(5);
      rdChk("loss rise", `LSIR_IDX_LINEFLAG, 8'h01);
      rdChk("live loss", `LSIR_IDX_LIVE, 8'h01);
      wr(`LSIR_IDX_LINEFLAG, 8'h01);
      losPin <= 1'b0;
      tick(5);
      rdChk("loss fall", `LSIR_IDX_LINEFLAG, 8'h01);
      check("loss irq masked", irq, 1'b0);
      // Gain band and current pointer gaps
      wr(`LSIR_IDX_TXJMODE, 8'h00);
      wr(`LSIR_IDX_RXJMODE, 8'h00);
      repeat (4) begin
         gain  <= 5'($urandom);
         txGap <= 7'($urandom);
         rxGap <= 7'($urandom);
         tick(4);
         rdChk("gain band", `LSIR_IDX_GAIN, {3'h0, gain});
         rdChk("tx gap", `LSIR_IDX_TXGAP, {1'b0, txGap});
         rdChk("rx gap", `LSIR_IDX_RXGAP, {1'b0, rxGap});
      end
      // Peak mode: a read opens the window, the gap swings by a known step
      wr(`LSIR_IDX_TXJMODE, 8'h20);
      txGap <= rxGap;
      xfer(1'b0, `LSIR_IDX_TXGAP, 8'h00, v);
      fm = {1'b0, rxGap ^ 7'h55};
      txGap <= fm[6:0];
      tick(3);
      txGap <= rxGap;
      tick(3);
      rdChk("tx gap peak", `LSIR_IDX_TXGAP, fm > rxGap ? fm - rxGap : rxGap - fm);
      // Swing again, then a write of ones must drop the old peak
      txGap <= fm[6:0];
      tick(3);
      txGap <= rxGap;
      wr(`LSIR_IDX_TXGAP, 8'h7f);
      tick(2);
      rdChk("tx gap cleared", `LSIR_IDX_TXGAP, 8'h00);
      // Zero-run counting and reporting against the integer model
      ami <= 1'b1;
      ctl(8'h00);
      zeros(20);
      ctl(8'h01);
      tick(2);
      rdChk("select off", `LSIR_IDX_CNTLO, 8'(expReport));
      wr(`LSIR_IDX_FAULTFLAG, 8'hff);
      ctl(8'h04);
      zeros(16);
      zeros(15);
      ami <= 1'b0;
      zeros(8);
      zeros(7);
      rdChk("zero run flag", `LSIR_IDX_FAULTFLAG, 8'h04);
      ctl(8'h05);
      tick(2);
      rdChk("count low", `LSIR_IDX_CNTLO, 8'(expReport));
      rdChk("count high", `LSIR_IDX_CNTHI, 8'(expReport >> 8));
      ctl(8'h04);
      zeros(16);
      ctl(8'h05);
      tick(2);
      rdChk("count restart", `LSIR_IDX_CNTLO, 8'(expReport));
      ctl(8'h06);
      tick(45);
      // At least two automatic transfers have passed by now
      expReport = expCount;
      rdChk("auto report", `LSIR_IDX_CNTLO, 8'(expReport));
      print_verdict();
   end
endmodule // lsir_regs_tb
`default_nettype wire
